// ---- hw/vfd_host_port.sv ----
// Host port (parallel and serial) with address counter
// Behaviour
// [R1] 4-bit: two transfers, upper nibble first, DB7-4
// [R2] 8-bit: one transfer on all eight lines
// [R3] Select low instruction, high data
// [R4] Enable mode: write on enable fall
// [R5] Enable mode: read driven after enable rise
// [R6] Strobe mode: write on write strobe rise
// [R7] Strobe mode: read driven after read fall
// [R8] Serial: two bytes, MSB first
// [R9] Host start byte: 11111, rw, sel, 0
// [R10] Start rw bit one means read
// [R11] Start sel bit picks instruction or data
// [R12] Serial write sampled on clock rise
// [R13] Serial read: start on rise, out on fall
// [R14] Host waits 1 us between bytes
// [R15] Frame opens on fall, valid on rise
// [R16] Automatic reset at power-up
// [R17] External reset in parallel modes only
// [R18] Host waits 100 us after reset
// [R19] Display up: 27H to 40H, 67H to 00H
// [R20] Display down: 40H to 27H, 00H to 67H
// [R21] Glyph steps wrap within 6 bits
// [R22] Display address doubles as cursor
// [R23] Busy indicator always reads zero
// [R24] Counter stays in display ranges
// [R25] Nibble phase starts upper, toggles per strobe
`timescale 1ns/1ns
module vfd_host_port (
  // Clock and power-up reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Jumper settings and external reset pin
  input wire logic [1:0] i_mode,
  input wire logic i_bus8,
  input wire logic i_ext_rst_sel,
  input wire logic i_ext_rst_n,
  // Parallel pins
  input wire vfd_host_pkg::par_pins_t i_par,
  output logic [7:0] o_data,
  output logic o_data_oe,
  // Serial pins, own clock
  input wire logic i_sck,
  input wire logic i_serial_frame_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  // User side: transfers
  output logic o_wr_valid,
  output vfd_host_pkg::xfer_t o_wr,
  output logic o_rd_valid,
  output vfd_host_pkg::xfer_t o_rd,
  input wire logic [7:0] i_ram_rdata,
  // User side: address counter
  input wire logic i_ac_load,
  input wire vfd_host_pkg::ac_load_t i_ac_load_val,
  input wire logic i_ac_up,
  output logic [6:0] o_addr_counter,
  output logic o_glyph_sel,
  output logic [6:0] o_cursor_pos,
  // User side: status
  output logic o_busy_indicator,
  output logic o_core_rst_n,
  output logic o_host_ready
);
  import vfd_host_pkg::*;

  // Address counter step with range wrapping
  function automatic logic [6:0] ac_step(
    input logic [6:0] a,
    input logic glyph,
    input logic up
  );
    logic [5:0] g;
    g = a[5:0];
    if (glyph)
    begin
      if (up)
        ac_step = {1'b0, (g == GLYPH_END) ? GLYPH_BEG : 6'(g + 6'h01)};
      else
        ac_step = {1'b0, (g == GLYPH_BEG) ? GLYPH_END : 6'(g - 6'h01)};
    end
    else if (up)
    begin
      if (a == DISP_LO_END)
        ac_step = DISP_HI_BEG;
      else if (a == DISP_HI_END)
        ac_step = DISP_LO_BEG;
      else
        ac_step = 7'(a + 7'h01);
    end
    else
    begin
      if (a == DISP_HI_BEG)
        ac_step = DISP_LO_END;
      else if (a == DISP_LO_BEG)
        ac_step = DISP_HI_END;
      else
        ac_step = 7'(a - 7'h01);
    end
  endfunction

  // ---------------- Serial clock domain ----------------
  logic [4:0] s_cnt_q;
  logic [6:0] s_sh_q;
  logic [7:0] s_start_q;
  logic [15:0] s_word_q;
  logic s_tgl_q;
  logic s_so_q;
  logic s_oe_q;
  logic [7:0] status_word_q;
  logic [7:0] data_word_q;
  wire s_rst_n = i_arst_n & ~i_serial_frame_n;
  wire s_busy = s_cnt_q != SER_FRAME_BITS;
  wire s_rw = s_start_q[START_RW_BIT];
  wire s_in_start = s_cnt_q < SER_BYTE_BITS;
  wire s_last = s_cnt_q == SER_LAST_BIT;
  wire [7:0] s_byte = {s_sh_q, i_si};
  wire [7:0] s_rd_word = s_start_q[START_SEL_BIT] ? data_word_q
                                                  : status_word_q;

  // Bit counter, cleared while the frame strobe is high
  always_ff @(posedge i_sck or negedge s_rst_n)
  begin
    if (!s_rst_n)
      s_cnt_q <= 5'h00;
    else if (s_busy)
      s_cnt_q <= 5'(s_cnt_q + 5'h01); // see [R8] [R15]
  end

  // Shift in on rising edges, MSB first
  always_ff @(posedge i_sck or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_sh_q <= 7'h00;
      s_start_q <= BYTE_RST;
      s_word_q <= 16'h0000;
      s_tgl_q <= 1'b0;
    end
    else if (!i_serial_frame_n && s_busy)
    begin
      s_sh_q <= s_byte[6:0]; // see [R12] [R13]
      if (s_cnt_q == SER_BYTE_BITS - 5'h01)
        s_start_q <= s_byte;
      if (s_last)
      begin
        s_word_q <= {s_start_q, s_rw ? BYTE_RST : s_byte}; // see [R10]
        s_tgl_q <= ~s_tgl_q;
      end
    end
  end

  // Read byte driven after each falling edge
  always_ff @(negedge i_sck or negedge s_rst_n)
  begin
    if (!s_rst_n)
    begin
      s_so_q <= 1'b0;
      s_oe_q <= 1'b0;
    end
    else if (s_rw && !s_in_start && s_busy)
    begin
      s_oe_q <= 1'b1;
      s_so_q <= s_rd_word[~s_cnt_q[2:0]]; // see [R13]
    end
  end

  assign o_so = s_so_q;
  assign o_so_oe = s_oe_q;

  // ---------------- Core clock domain ----------------
  logic [4:0] cfg1_q;
  logic [4:0] cfg2_q;
  par_pins_t p1_q;
  par_pins_t p2_q;
  par_pins_t p3_q;
  logic [2:0] tgl_q;
  logic [2:0] frm_q;
  logic pend_q;
  par_state_t state_q;
  par_state_t state_d;
  logic nib_q;
  logic [3:0] hi_q;
  logic rd_sel_q;
  logic [6:0] ac_q;
  logic glyph_q;
  logic [11:0] boot_q;
  logic [7:0] data_q;
  logic data_oe_q;
  logic wr_valid_q;
  xfer_t wr_q;
  logic rd_valid_q;
  xfer_t rd_q;
  logic [6:0] cursor_q;
  logic ready_q;

  // Pin synchronisers
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cfg1_q <= 5'h01;
      cfg2_q <= 5'h01;
      p1_q <= PAR_IDLE; // Idle levels, no false edge after reset
      p2_q <= PAR_IDLE;
      p3_q <= PAR_IDLE;
      tgl_q <= 3'h0;
      frm_q <= 3'h7;
    end
    else
    begin
      cfg1_q <= {i_mode, i_bus8, i_ext_rst_sel, i_ext_rst_n};
      cfg2_q <= cfg1_q;
      p1_q <= i_par;
      p2_q <= p1_q;
      p3_q <= p2_q;
      tgl_q <= {tgl_q[1:0], s_tgl_q};
      frm_q <= {frm_q[1:0], i_serial_frame_n};
    end
  end

  // Settings and reset decode
  wire [1:0] mode = cfg2_q[4:3];
  wire bus8 = cfg2_q[2];
  wire is_ser = mode == MODE_SER;
  wire is_estb = mode == MODE_ESTB;
  wire is_sstb = mode == MODE_SSTB;
  wire ext_rst = cfg2_q[1] & ~cfg2_q[0] & ~is_ser; // see [R17]
  wire last_nib = bus8 | nib_q; // see [R1] [R2]

  // Parallel strobe edges
  wire e_fall = p3_q.en & ~p2_q.en;
  wire e_rise = ~p3_q.en & p2_q.en;
  wire wr_ev = is_estb ? e_fall & ~p3_q.rw // see [R4]
                       : is_sstb & ~p3_q.wr_n & p2_q.wr_n; // see [R6]
  wire rd_beg = is_estb ? e_rise & p2_q.rw // see [R5]
                        : is_sstb & p3_q.rd_n & ~p2_q.rd_n; // see [R7]
  wire rd_end = is_estb ? e_fall & p3_q.rw
                        : is_sstb & ~p3_q.rd_n & p2_q.rd_n;

  // Read value: status word or RAM byte
  wire [7:0] rd_val = p2_q.sel ? data_word_q : status_word_q; // see [R3]
  wire [7:0] drive_val = bus8 ? rd_val
                       : nib_q ? {rd_val[3:0], 4'h0}
                               : {rd_val[7:4], 4'h0}; // see [R1]

  // Serial frame acceptance
  wire tgl_ev = tgl_q[2] ^ tgl_q[1];
  wire frm_rise = ~frm_q[2] & frm_q[1];
  wire frm_fall = frm_q[2] & ~frm_q[1];
  wire start_ok = s_word_q[15:11] == START_ONES
                & ~s_word_q[8]; // see [R9]
  wire ser_ok = is_ser & frm_rise & pend_q & start_ok; // see [R15]
  wire ser_rw = s_word_q[8 + START_RW_BIT]; // see [R10]
  wire ser_sel = s_word_q[8 + START_SEL_BIT]; // see [R11]

  // Completed transfers
  wire par_wr = wr_ev & last_nib;
  wire par_rd = rd_end & last_nib;
  wire [7:0] par_byte = bus8 ? p3_q.data
                             : {hi_q, p3_q.data[7:4]}; // see [R1]
  wire any_wr = par_wr | (ser_ok & ~ser_rw);
  wire any_rd = par_rd | (ser_ok & ser_rw);
  wire wr_sel = is_ser ? ser_sel : p3_q.sel; // see [R3]
  wire rd_sel = is_ser ? ser_sel : rd_sel_q;
  wire [7:0] wr_byte = is_ser ? s_word_q[7:0] : par_byte;
  wire step = (any_wr & wr_sel) | (any_rd & rd_sel);

  // Parallel port state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      P_IDLE:
        if (ext_rst)
          state_d = P_RESET;
        else if (rd_beg)
          state_d = P_READ;
      P_READ:
        if (ext_rst)
          state_d = P_RESET;
        else if (rd_end)
          state_d = P_IDLE;
      P_RESET:
        if (!ext_rst)
          state_d = P_IDLE;
      default:
        state_d = P_RESET;
    endcase
  end

  wire soft_rst = state_q == P_RESET;

  // Port state, nibble phase and bus drive
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_q <= P_RESET; // see [R16]
      nib_q <= 1'b0;
      hi_q <= 4'h0;
      rd_sel_q <= 1'b0;
      data_q <= BYTE_RST;
      data_oe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (soft_rst || bus8)
        nib_q <= 1'b0; // see [R25]
      else if (wr_ev || rd_end)
        nib_q <= ~nib_q; // see [R25]
      if (wr_ev && !nib_q)
        hi_q <= p3_q.data[7:4]; // see [R1]
      if (rd_beg)
        rd_sel_q <= p2_q.sel;
      if (rd_beg)
        data_q <= drive_val;
      data_oe_q <= state_d == P_READ;
    end
  end

  // Frame pending between last bit and strobe rise
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      pend_q <= 1'b0;
    else if (tgl_ev)
      pend_q <= 1'b1;
    else if (frm_fall || frm_rise)
      pend_q <= 1'b0;
  end

  // Address counter, load wins over a step
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ac_q <= AC_RST;
      glyph_q <= 1'b0;
    end
    else if (soft_rst)
    begin
      ac_q <= AC_RST;
      glyph_q <= 1'b0;
    end
    else if (i_ac_load)
    begin
      ac_q <= i_ac_load_val.value;
      glyph_q <= i_ac_load_val.glyph;
    end
    else if (step)
      ac_q <= ac_step(ac_q, glyph_q, i_ac_up); // see [R19] [R20] [R21] [R24]
  end

  // Read words, also used by the serial side
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      status_word_q <= BYTE_RST;
      data_word_q <= BYTE_RST;
    end
    else
    begin
      status_word_q <= {1'b0, ac_q}; // see [R23]
      data_word_q <= i_ram_rdata;
    end
  end

  // User side transfer strobes
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_valid_q <= 1'b0;
      wr_q <= '0;
      rd_valid_q <= 1'b0;
      rd_q <= '0;
    end
    else
    begin
      wr_valid_q <= any_wr & ~soft_rst;
      rd_valid_q <= any_rd & ~soft_rst;
      if (any_wr)
        wr_q <= '{sel: wr_sel, data: wr_byte}; // see [R3] [R11]
      if (any_rd)
        rd_q <= '{sel: rd_sel, data: rd_sel ? data_word_q : status_word_q};
    end
  end

  // Cursor, boot wait and status flags
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cursor_q <= AC_RST;
      boot_q <= 12'h000;
      ready_q <= 1'b0;
    end
    else
    begin
      if (!glyph_q)
        cursor_q <= ac_q; // see [R22]
      if (soft_rst)
        boot_q <= 12'h000;
      else if (boot_q != BOOT_LAST)
        boot_q <= 12'(boot_q + 12'h001);
      ready_q <= ~soft_rst & (boot_q == BOOT_LAST); // see [R18]
    end
  end

  // Outputs
  assign o_data = data_q;
  assign o_data_oe = data_oe_q;
  assign o_wr_valid = wr_valid_q;
  assign o_wr = wr_q;
  assign o_rd_valid = rd_valid_q;
  assign o_rd = rd_q;
  assign o_addr_counter = ac_q;
  assign o_glyph_sel = glyph_q;
  assign o_cursor_pos = cursor_q;
  assign o_busy_indicator = 1'b0; // see [R23]
  assign o_core_rst_n = ~soft_rst;
  assign o_host_ready = ready_q;
endmodule

// ---- hw/vfd_host_pkg.sv ----
// Constants and types of the display host port and address counter
package vfd_host_pkg;
  // Interface mode selections
  localparam logic [1:0] MODE_ESTB = 2'h0;
  localparam logic [1:0] MODE_SSTB = 2'h1;
  localparam logic [1:0] MODE_SER = 2'h2;
  // Display RAM address ranges
  localparam logic [6:0] DISP_LO_BEG = 7'h00;
  localparam logic [6:0] DISP_LO_END = 7'h27;
  localparam logic [6:0] DISP_HI_BEG = 7'h40;
  localparam logic [6:0] DISP_HI_END = 7'h67;
  // Glyph RAM range ends
  localparam logic [5:0] GLYPH_BEG = 6'h00;
  localparam logic [5:0] GLYPH_END = 6'h3F;
  // Reset values
  localparam logic [6:0] AC_RST = 7'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Serial frame layout
  localparam logic [4:0] START_ONES = 5'h1F;
  localparam int START_RW_BIT = 2;
  localparam int START_SEL_BIT = 1;
  localparam logic [4:0] SER_BYTE_BITS = 5'h08;
  localparam logic [4:0] SER_LAST_BIT = 5'h0F;
  localparam logic [4:0] SER_FRAME_BITS = 5'h10;
  // Host wait after reset
  localparam int T_BOOT_NS = 100000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int BOOT_CYC = (T_BOOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] BOOT_LAST = 12'(BOOT_CYC - 1);

  // Parallel pins as sampled together
  typedef struct packed {
    logic [7:0] data;
    logic sel;
    logic rw;
    logic en;
    logic wr_n;
    logic rd_n;
  } par_pins_t;

  // Idle level of the parallel pins, enable low
  localparam par_pins_t PAR_IDLE = '{data: 8'hFF, sel: 1'b1, rw: 1'b1,
    en: 1'b0, wr_n: 1'b1, rd_n: 1'b1};

  // One completed transfer towards the user side
  typedef struct packed {
    logic sel;
    logic [7:0] data;
  } xfer_t;

  // Address counter load request
  typedef struct packed {
    logic glyph;
    logic [6:0] value;
  } ac_load_t;

  // Parallel port state
  typedef enum logic [2:0] {
    P_IDLE = 3'b001,
    P_READ = 3'b010,
    P_RESET = 3'b100
  } par_state_t;
endpackage

// ---- testbench/vfd_host_port_checker.sv ----
// Assertions on the display host port
`timescale 1ns/1ns
module vfd_host_port_checker (
  // Clock, reset and settings
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [1:0] i_mode,
  input wire logic i_bus8,
  input wire logic i_ext_rst_sel,
  input wire logic i_ext_rst_n,
  // Pins and user inputs
  input wire vfd_host_pkg::par_pins_t i_par,
  input wire logic i_serial_frame_n,
  input wire logic i_ac_load,
  input wire logic i_ac_up,
  // Outputs
  input wire logic o_wr_valid,
  input wire vfd_host_pkg::xfer_t o_wr,
  input wire logic o_data_oe,
  input wire logic o_so_oe,
  input wire logic [6:0] o_addr_counter,
  input wire logic o_glyph_sel,
  input wire logic [6:0] o_cursor_pos,
  input wire logic o_busy_indicator,
  input wire logic o_core_rst_n,
  input wire logic o_host_ready
);
  import vfd_host_pkg::*;
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  // Counter value after one step
  function automatic logic [6:0] stp(logic [6:0] a, logic g, logic u);
    if (g)
      return {1'b0, a[5:0] + (u ? 6'h01 : 6'h3F)};
    if (u)
      return a == 7'h27 ? 7'h40 : a == 7'h67 ? 7'h00 : a + 7'h01;
    return a == 7'h40 ? 7'h27 : a == 7'h00 ? 7'h67 : a - 7'h01;
  endfunction
  // Read opened by the enable, then the bus driven
  sequence rd_start;
    $rose(i_par.en) && i_par.rw && i_mode == MODE_ESTB && o_host_ready;
  endsequence
  sequence oe_soon;
    ##[1:5] o_data_oe;
  endsequence
  busy_zero_a: assert property (o_busy_indicator == 1'b0)
    else $error("busy indicator set");
  counter_step_a: assert property (
    o_wr_valid && o_wr.sel && !$past(i_ac_load) |->
    o_addr_counter == stp($past(o_addr_counter), $past(o_glyph_sel),
    $past(i_ac_up)))
    else $error("counter step wrong");
  disp_range_a: assert property (!o_glyph_sel |->
    o_addr_counter <= 7'h27 ||
    (o_addr_counter >= 7'h40 && o_addr_counter <= 7'h67))
    else $error("counter out of range");
  cursor_track_a: assert property (
    !o_glyph_sel && $past(o_glyph_sel) == 1'b0 &&
    $stable(o_addr_counter) |-> o_cursor_pos == o_addr_counter)
    else $error("cursor apart from counter");
  frame_release_a: assert property (
    o_so_oe |-> !i_serial_frame_n)
    else $error("serial line driven outside frame");
  read_drive_a: assert property (rd_start |-> oe_soon)
    else $error("read data not driven");
  write_latch_a: assert property (
    $rose(i_par.wr_n) && i_mode == MODE_SSTB && i_bus8 && o_host_ready
    |-> ##[1:5] o_wr_valid)
    else $error("strobe write not taken");
  ext_reset_a: assert property (
    i_ext_rst_sel && !i_ext_rst_n && i_mode != MODE_SER |->
    ##[1:5] !o_core_rst_n)
    else $error("external reset ignored");
endmodule
bind vfd_host_port vfd_host_port_checker chk (
  .i_clk, .i_arst_n, .i_mode, .i_bus8, .i_ext_rst_sel, .i_ext_rst_n,
  .i_par, .i_serial_frame_n, .i_ac_load, .i_ac_up, .o_wr_valid, .o_wr,
  .o_data_oe, .o_so_oe, .o_addr_counter, .o_glyph_sel, .o_cursor_pos,
  .o_busy_indicator, .o_core_rst_n, .o_host_ready
);

// ---- testbench/vfd_host_model.sv ----
// Host controller model for the parallel and serial pins
`timescale 1ns/1ns
module vfd_host_model (
  // Pins towards the device
  output vfd_host_pkg::par_pins_t o_par,
  output logic o_sck,
  output logic o_frame_n,
  output logic o_si,
  // Answers from the device
  input wire logic [7:0] i_data,
  input wire logic i_so
);
  import vfd_host_pkg::*;
  // Idle lines pulled high, enable low
  initial
  begin
    o_par = PAR_IDLE;
    o_sck = 1'b1;
    o_frame_n = 1'b1;
    o_si = 1'b1;
  end
  // One byte as one or two strobed transfers
  task automatic par_xfer(input logic s, b8, rw, sel,
    input logic [7:0] b, output logic [7:0] r);
    for (int i = 0; i < (b8 ? 1 : 2); i++)
    begin
      o_par.sel = sel;
      o_par.rw = rw;
      if (!rw)
        o_par.data = b8 ? b : {i ? b[3:0] : b[7:4], 4'hF};
      #100;
      if (s && rw)
        o_par.rd_n = 1'b0;
      else if (s)
        o_par.wr_n = 1'b0;
      else
        o_par.en = 1'b1;
      #400;
      if (b8)
        r = i_data;
      else if (i == 0)
        r[7:4] = i_data[7:4];
      else
        r[3:0] = i_data[7:4];
      o_par.en = 1'b0;
      o_par.wr_n = 1'b1;
      o_par.rd_n = 1'b1;
      #100;
      o_par.data = 8'hFF;
      #300;
    end
  endtask
  // One framed serial cycle; clock runs only inside it
  task automatic ser_frame(input logic rw, sel, input logic [7:0] b,
    input int n, input logic bad, output logic [7:0] r);
    logic [15:0] w;
    w = {5'h1F, rw, sel, bad, b};
    o_frame_n = 1'b0;
    #200;
    for (int i = 15; i >= 16 - n; i--)
    begin
      if (i == 7)
        #1000;
      o_sck = 1'b0;
      o_si = (rw && i < 8) ? ~o_si : w[i];
      #5;
      if (i < 8)
        r[i] = i_so;
      #1;
      o_sck = 1'b1;
      #6;
    end
    #600;
    o_frame_n = 1'b1;
    o_si = 1'b1;
    #600;
  endtask
endmodule

// ---- testbench/vfd_host_port_test.sv ----
// Self-checking bench for the display host port
`timescale 1ns/1ns
module vfd_host_port_test;
  import vfd_host_pkg::*;
  typedef struct packed {
    logic g;
    logic [6:0] v;
    logic up;
    logic [6:0] e;
  } row_t;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [1:0] i_mode = MODE_ESTB;
  logic i_bus8 = 1'b1;
  logic i_ext_rst_sel = 1'b1;
  logic i_ext_rst_n = 1'b1;
  logic i_ac_load = 1'b0;
  logic i_ac_up = 1'b1;
  ac_load_t i_ac_load_val = '0;
  par_pins_t i_par;
  logic i_sck, i_serial_frame_n, i_si, o_so, o_wr_valid, o_glyph_sel;
  logic o_busy_indicator, o_core_rst_n, o_host_ready, o_rd_valid;
  logic [7:0] o_data, r;
  logic [6:0] o_addr_counter, o_cursor_pos;
  xfer_t o_wr, o_rd;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  int w0, r0;
  // Load, direction and expected counter after one data write
  row_t rows [7] = '{
    '{1'b0, 7'h27, 1'b1, 7'h40},
    '{1'b0, 7'h67, 1'b1, 7'h00},
    '{1'b0, 7'h05, 1'b1, 7'h06},
    '{1'b0, 7'h40, 1'b0, 7'h27},
    '{1'b0, 7'h00, 1'b0, 7'h67},
    '{1'b1, 7'h3F, 1'b1, 7'h00},
    '{1'b1, 7'h00, 1'b0, 7'h3F}};
  vfd_host_port uut (
    .i_clk, .i_arst_n, .i_mode, .i_bus8, .i_ext_rst_sel, .i_ext_rst_n,
    .i_par, .o_data, .o_data_oe(), .i_sck, .i_serial_frame_n, .i_si,
    .o_so, .o_so_oe(), .o_wr_valid, .o_wr, .o_rd_valid, .o_rd,
    .i_ram_rdata(8'hA5), .i_ac_load, .i_ac_load_val, .i_ac_up,
    .o_addr_counter, .o_glyph_sel, .o_cursor_pos, .o_busy_indicator,
    .o_core_rst_n, .o_host_ready
  );
  vfd_host_model host (
    .o_par(i_par), .o_sck(i_sck), .o_frame_n(i_serial_frame_n),
    .o_si(i_si), .i_data(o_data), .i_so(o_so)
  );
  always #25 i_clk = ~i_clk;
  // Cycle, write and read pulse counts, hang cut-off
  always @(negedge i_clk)
  begin
    cyc++;
    if (o_wr_valid === 1'b1)
      wr_cnt++;
    if (o_rd_valid === 1'b1)
      rd_cnt++;
    if (cyc == 40000)
    begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude;
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [8:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_ready;
    for (int k = 0; k < 2100 && o_host_ready !== 1'b1; k++)
    begin
      @(posedge i_clk);
      #5;
    end
    chk("ready", 9'h001, {8'h00, o_host_ready});
  endtask
  task automatic restart(input logic [1:0] m, input logic b8);
    i_arst_n = 1'b0;
    i_mode = m;
    i_bus8 = b8;
    repeat (12) @(posedge i_clk);
    #5;
    i_arst_n = 1'b1;
    wait_ready();
  endtask
  task automatic load(input logic g, input logic [6:0] v, input logic u);
    i_ac_load_val = '{g, v};
    i_ac_load = 1'b1;
    i_ac_up = u;
    @(posedge i_clk);
    #5;
    i_ac_load = 1'b0;
    repeat (2) @(posedge i_clk);
    #5;
  endtask
  task automatic par(input logic s, b, rw, sel, input logic [7:0] d);
    host.par_xfer(s, b, rw, sel, d, r);
    repeat (8) @(posedge i_clk);
    #5;
  endtask
  task automatic ser(input logic rw, sel, bad, input logic [7:0] d,
    input int n);
    host.ser_frame(rw, sel, d, n, bad, r);
    repeat (8) @(posedge i_clk);
    #5;
  endtask
  task automatic ext_pulse(input logic x);
    i_ext_rst_n = 1'b0;
    repeat (10) @(posedge i_clk);
    #5;
    chk("core reset", {8'h00, !x}, {8'h00, o_core_rst_n});
    i_ext_rst_n = 1'b1;
    wait_ready();
  endtask
  // Main sequence
  initial
  begin
    restart(MODE_ESTB, 1'b1);
    chk("ready", 9'h001, {8'h00, o_host_ready});
    chk("counter", 9'h000, {2'h0, o_addr_counter});
    chk("busy", 9'h000, {8'h00, o_busy_indicator});
    foreach (rows[i])
    begin
      load(rows[i].g, rows[i].v, rows[i].up);
      par(1'b0, 1'b1, 1'b0, 1'b1, 8'h30 + 8'(i));
      chk("written", {1'b1, 8'h30 + 8'(i)}, o_wr);
      chk("step", 9'(rows[i].e), 9'(o_addr_counter));
    end
    load(1'b0, 7'h12, 1'b1);
    chk("cursor", 9'h012, {2'h0, o_cursor_pos});
    par(1'b0, 1'b1, 1'b1, 1'b0, 8'hFF);
    chk("status", 9'h012, {1'b0, r});
    chk("read out", 9'h012, o_rd);
    ext_pulse(1'b1);
    chk("counter", 9'h000, {2'h0, o_addr_counter});
    // Nibble transfers
    restart(MODE_ESTB, 1'b0);
    w0 = wr_cnt;
    par(1'b0, 1'b0, 1'b0, 1'b0, 8'h5A);
    chk("nibble write", 9'h05A, o_wr);
    chk("write count", 9'h001, 9'(wr_cnt - w0));
    load(1'b0, 7'h23, 1'b1);
    r0 = rd_cnt;
    par(1'b0, 1'b0, 1'b1, 1'b0, 8'hFF);
    chk("nibble read", 9'h023, {1'b0, r});
    chk("read count", 9'h001, 9'(rd_cnt - r0));
    // Separate strobes
    restart(MODE_SSTB, 1'b1);
    load(1'b0, 7'h27, 1'b1);
    par(1'b1, 1'b1, 1'b0, 1'b1, 8'hE7);
    chk("strobe write", 9'h1E7, o_wr);
    chk("counter", 9'h040, {2'h0, o_addr_counter});
    par(1'b1, 1'b1, 1'b1, 1'b1, 8'hFF);
    chk("strobe read", 9'h0A5, {1'b0, r});
    chk("strobe read out", 9'h1A5, o_rd);
    chk("counter", 9'h041, {2'h0, o_addr_counter});
    // External reset pin ignored while its setting is off
    i_ext_rst_sel = 1'b0;
    repeat (3) @(posedge i_clk);
    #5;
    ext_pulse(1'b0);
    chk("counter", 9'h041, {2'h0, o_addr_counter});
    i_ext_rst_sel = 1'b1;
    // Serial frames: write, read, malformed, short
    restart(MODE_SER, 1'b1);
    load(1'b0, 7'h10, 1'b0);
    ser(1'b0, 1'b1, 1'b0, 8'h96, 16);
    chk("serial write", 9'h196, o_wr);
    chk("counter", 9'h00F, {2'h0, o_addr_counter});
    ser(1'b1, 1'b0, 1'b0, 8'hFF, 16);
    chk("serial read", 9'h00F, {1'b0, r});
    chk("serial read out", 9'h00F, o_rd);
    w0 = wr_cnt;
    ser(1'b0, 1'b0, 1'b1, 8'h11, 16);
    ser(1'b0, 1'b0, 1'b0, 8'h22, 12);
    chk("refused", 9'h000, 9'(wr_cnt - w0));
    ext_pulse(1'b0);
    chk("counter", 9'h00F, {2'h0, o_addr_counter});
    conclude();
  end
endmodule
